// ---- rtl/aot_timer.sv ----
// Auto-off timer with sustain/cancel override for a toggle touch key
`timescale 1ns/10ps
`include "aot_params.svh"
module aot_timer
    import aot_pkg::*;
#(
    parameter int unsigned SETTLE_CYC  = `AOT_SETTLE_CYC,
    parameter int unsigned RECAL_CYC   = `AOT_RECAL_CYC,
    parameter int unsigned SUSTAIN_CYC = `AOT_SUSTAIN_CYC,
    parameter int unsigned CANCEL_CYC  = `AOT_CANCEL_CYC,
    parameter longint unsigned MIN_CYC = 64'(`AOT_MS_PER_MIN) * 64'(`AOT_CYC_PER_MS)
) (
    input  wire logic    SYS_CLK,
    input  wire logic    RST_N,
    input  wire aot_in_t SENSE_IN,
    output logic         KEY_OUT,
    output logic         OUT_VALID,
    output logic         BURST_EN,
    output logic         RECAL_BUSY
);
    // Base delays in clock cycles; a bench may shrink MIN_CYC to reach them
    localparam longint unsigned T15 = 64'(`AOT_BASE15_MIN) * MIN_CYC;
    localparam longint unsigned T60 = 64'(`AOT_BASE60_MIN) * MIN_CYC;

    aot_state_t  state;
    aot_state_t  next_state;
    logic [31:0] phase_cnt;
    logic [31:0] next_phase_cnt;
    logic [31:0] ovr_cnt;
    logic [31:0] next_ovr_cnt;
    logic [63:0] off_cnt;
    logic [63:0] next_off_cnt;
    logic        on_state;
    logic        next_on_state;
    logic        ref_level;
    logic        next_ref_level;
    logic        mult24;
    logic        next_mult24;
    logic        line_ovr;
    logic [63:0] delay_cyc;
    logic [63:0] base_cyc;
    logic        no_auto_off;

    // Next values of the output flops
    logic        next_key_out;
    logic        next_out_valid;
    logic        next_burst_en;
    logic        next_recal_busy;

    // Override means away from the strap level, so either strap can be pulsed
    assign line_ovr = SENSE_IN.mult_level != ref_level;

    // Delay counts are 64 bits: an hour times twenty-four overflows 32 bits at this clock
    always_comb begin
        no_auto_off = 1'b0;
        base_cyc    = T15;
        // Polarity swaps the meaning of the low and high straps
        case (SENSE_IN.time_sel)
            `AOT_TIME_LOW: begin
                no_auto_off = !SENSE_IN.active_low;
            end
            `AOT_TIME_HIGH: begin
                no_auto_off = SENSE_IN.active_low;
            end
            `AOT_TIME_OUT: begin
                base_cyc = T60;
            end
            default: begin
                base_cyc = T15;
            end
        endcase
        if (mult24) begin
            delay_cyc = base_cyc * 64'(`AOT_MULT_HIGH);
        end else begin
            delay_cyc = base_cyc * 64'(`AOT_MULT_LOW);
        end
    end

    always_comb begin
        next_state     = state;
        next_phase_cnt = phase_cnt;
        next_ovr_cnt   = ovr_cnt;
        next_off_cnt   = off_cnt;
        next_on_state  = on_state;
        next_ref_level = ref_level;
        next_mult24    = mult24;
        case (state)
            AOT_SETTLE: begin
                // Load held off while the supplies settle
                next_on_state = 1'b0;
                if (phase_cnt >= SETTLE_CYC - 1) begin
                    next_state     = AOT_RECAL;
                    next_phase_cnt = 32'h0000_0000;
                    // Strap is taken on the last settle cycle, after the line has settled
                    next_ref_level = SENSE_IN.mult_level;
                    next_mult24    = SENSE_IN.mult_level;
                end else begin
                    next_phase_cnt = phase_cnt + 32'h0000_0001;
                end
            end
            AOT_RECAL: begin
                // Output state is left as it was on entry
                if (phase_cnt >= RECAL_CYC - 1) begin
                    next_state     = AOT_RUN;
                    next_phase_cnt = 32'h0000_0000;
                end else begin
                    next_phase_cnt = phase_cnt + 32'h0000_0001;
                end
            end
            AOT_RUN: begin
                // Override entry beats a touch on a cycle_end cycle; a touch between cycle ends still toggles
                if (SENSE_IN.cycle_end && line_ovr) begin
                    next_state   = AOT_HOLD;
                    next_ovr_cnt = 32'h0000_0001;
                end else if (SENSE_IN.touch) begin
                    // A touch also restarts the delay
                    next_on_state = !on_state;
                    next_off_cnt  = 64'h0000_0000_0000_0000;
                end else if (on_state && !no_auto_off) begin
                    if (off_cnt >= delay_cyc - 64'h0000_0000_0000_0001) begin
                        next_on_state = 1'b0;
                        next_off_cnt  = 64'h0000_0000_0000_0000;
                    end else begin
                        next_off_cnt = off_cnt + 64'h0000_0000_0000_0001;
                    end
                end
            end
            AOT_HOLD: begin
                // No bursts in this state; the line is timed until it returns
                // A return before the sustain count is a glitch and reloads nothing
                if (!line_ovr) begin
                    next_state     = AOT_RECAL;
                    next_phase_cnt = 32'h0000_0000;
                    if (ovr_cnt >= SUSTAIN_CYC) begin
                        next_off_cnt = 64'h0000_0000_0000_0000;
                    end
                end else if (ovr_cnt >= CANCEL_CYC) begin
                    next_state    = AOT_CANCEL;
                    next_on_state = 1'b0;
                end else begin
                    next_ovr_cnt = ovr_cnt + 32'h0000_0001;
                end
            end
            AOT_CANCEL: begin
                // Touches are dropped until the line is back at its strap level
                if (!line_ovr) begin
                    next_state     = AOT_RECAL;
                    next_phase_cnt = 32'h0000_0000;
                    next_off_cnt   = 64'h0000_0000_0000_0000;
                end
            end
            default: begin
                next_state     = AOT_SETTLE;
                next_phase_cnt = 32'h0000_0000;
            end
        endcase
    end

    // Output levels are worked out here so that every port comes from a flop
    always_comb begin
        next_key_out    = next_on_state ^ SENSE_IN.active_low;
        next_out_valid  = next_state != AOT_SETTLE;
        next_burst_en   = next_state == AOT_RUN || next_state == AOT_RECAL;
        next_recal_busy = next_state == AOT_RECAL;
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state     <= AOT_SETTLE;
            phase_cnt <= 32'h0000_0000;
            ovr_cnt   <= 32'h0000_0000;
            ref_level <= 1'b0;
            mult24    <= 1'b0;
        end else begin
            state     <= next_state;
            phase_cnt <= next_phase_cnt;
            ovr_cnt   <= next_ovr_cnt;
            ref_level <= next_ref_level;
            mult24    <= next_mult24;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            off_cnt  <= 64'h0000_0000_0000_0000;
            on_state <= 1'b0;
        end else begin
            off_cnt  <= next_off_cnt;
            on_state <= next_on_state;
        end
    end

    // Load pin is low through reset whatever the polarity strap says
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            KEY_OUT    <= 1'b0;
            OUT_VALID  <= 1'b0;
            BURST_EN   <= 1'b0;
            RECAL_BUSY <= 1'b0;
        end else begin
            KEY_OUT    <= next_key_out;
            OUT_VALID  <= next_out_valid;
            BURST_EN   <= next_burst_en;
            RECAL_BUSY <= next_recal_busy;
        end
    end
endmodule : aot_timer

// ---- rtl/aot_params.svh ----
// Timing counts and encodings for the auto-off override timer
`ifndef AOT_PARAMS_SVH
`define AOT_PARAMS_SVH
`define AOT_CLK_MHZ          125
`define AOT_SETTLE_MS        250
`define AOT_RECAL_MS         200
`define AOT_SUSTAIN_MS       65
`define AOT_CANCEL_MS        250
`define AOT_BASE15_MIN       15
`define AOT_BASE60_MIN       60
`define AOT_MULT_LOW         1
`define AOT_MULT_HIGH        24
`define AOT_CYC_PER_MS       (`AOT_CLK_MHZ * 1000)
`define AOT_SETTLE_CYC       (`AOT_SETTLE_MS * `AOT_CYC_PER_MS)
`define AOT_RECAL_CYC        (`AOT_RECAL_MS * `AOT_CYC_PER_MS)
`define AOT_SUSTAIN_CYC      (`AOT_SUSTAIN_MS * `AOT_CYC_PER_MS / 2)
`define AOT_CANCEL_CYC       ((`AOT_SUSTAIN_MS + `AOT_CANCEL_MS) * `AOT_CYC_PER_MS / 2)
`define AOT_MS_PER_MIN       60000
`define AOT_TIME_LOW         2'h0
`define AOT_TIME_HIGH        2'h1
`define AOT_TIME_OUT         2'h2
`endif

// ---- rtl/aot_pkg.sv ----
// Types for the auto-off override timer
package aot_pkg;
    typedef enum logic [4:0] {
        AOT_SETTLE = 5'b0_0001,
        AOT_RECAL  = 5'b0_0010,
        AOT_RUN    = 5'b0_0100,
        AOT_HOLD   = 5'b0_1000,
        AOT_CANCEL = 5'b1_0000
    } aot_state_t;
    typedef struct packed {
        logic       touch;
        logic       cycle_end;
        logic       mult_level;
        logic [1:0] time_sel;
        logic       active_low;
    } aot_in_t;
endpackage : aot_pkg

// ---- verification/aot_timer_props.sv ----
// Port checker for the auto-off override timer
`timescale 1ns/10ps
module aot_timer_props
    import aot_pkg::*;
(
    input wire logic    SYS_CLK,
    input wire logic    RST_N,
    input wire aot_in_t SENSE_IN,
    input wire logic    KEY_OUT,
    input wire logic    OUT_VALID,
    input wire logic    BURST_EN,
    input wire logic    RECAL_BUSY
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    logic run;
    assign run = BURST_EN && !RECAL_BUSY;
    settle_invalid_a: assert property ($rose(RST_N) |-> !OUT_VALID [*8])
        else $error("output valid during settling");
    valid_hold_a: assert property (OUT_VALID |=> OUT_VALID)
        else $error("output valid dropped");
    settle_quiet_a: assert property (!OUT_VALID |-> !BURST_EN && !RECAL_BUSY)
        else $error("activity during settling");
    recal_burst_a: assert property (RECAL_BUSY |-> BURST_EN)
        else $error("no bursts in recalibration");
    recal_entry_a: assert property ($rose(BURST_EN) |-> RECAL_BUSY)
        else $error("bursts resumed without recalibration");
    touch_toggle_a: assert property (run && SENSE_IN.touch && !SENSE_IN.cycle_end
        |-> ##[1:2] KEY_OUT != $past(KEY_OUT)) else $error("touch did not toggle");
    hold_off_only_a: assert property (OUT_VALID && !BURST_EN
        |=> KEY_OUT == $past(KEY_OUT) || KEY_OUT == SENSE_IN.active_low)
        else $error("output turned on while bursts stopped");
    recal_keep_a: assert property (RECAL_BUSY ##1 RECAL_BUSY
        |=> !$changed(KEY_OUT) || KEY_OUT == SENSE_IN.active_low)
        else $error("output turned on in recalibration");
endmodule : aot_timer_props
bind aot_timer aot_timer_props i_props (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .SENSE_IN(SENSE_IN),
    .KEY_OUT(KEY_OUT), .OUT_VALID(OUT_VALID), .BURST_EN(BURST_EN), .RECAL_BUSY(RECAL_BUSY));

// ---- verification/aot_host.sv ----
// Host model that pulses the multiplier line away from its strapped level
`timescale 1ns/10ps
module aot_host (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [7:0] len,
    input  wire logic       ref_lvl,
    output logic            line
);
    logic [7:0] cnt = 8'h00;
    // Pulse is held whole for len cycles
    always_ff @(posedge clk) cnt <= go ? len : ((cnt != 8'h00) ? cnt - 8'h01 : 8'h00);
    assign line = ref_lvl ^ (cnt != 8'h00);
endmodule : aot_host

// ---- verification/tb_auto_off_override_timer.sv ----
// Self-checking bench for the auto-off override timer
`timescale 1ns/10ps
module tb_auto_off_override_timer import aot_pkg::*;;
    logic       SYS_CLK = 1'b0;
    logic       RST_N   = 1'b0;
    logic       touch   = 1'b0;
    logic       cyc_end = 1'b0;
    logic       go      = 1'b0;
    logic [7:0] len     = 8'h00;
    logic       mult    = 1'b0;
    logic [1:0] tsel    = 2'h1;
    logic       pol     = 1'b0;
    logic       line, key_out, out_valid, burst_en, recal_busy;
    aot_in_t    sense;
    int         n_fail  = 0;
    int         n_tests = 0;
    logic [3:0] cfg [6] = '{4'h2, 4'h4, 4'h0, 4'ha, 4'h1, 4'h3};
    assign sense = '{touch, cyc_end, line, tsel, pol};
    initial forever #4 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) cyc_end <= ~cyc_end;
    aot_host i_host (.clk(SYS_CLK), .go(go), .len(len), .ref_lvl(mult), .line(line));
    aot_timer #(.SETTLE_CYC(20), .RECAL_CYC(20), .SUSTAIN_CYC(4), .CANCEL_CYC(16), .MIN_CYC(10))
        i_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .SENSE_IN(sense), .KEY_OUT(key_out),
        .OUT_VALID(out_valid), .BURST_EN(burst_en), .RECAL_BUSY(recal_busy));
    task automatic chk(input logic seen, input logic exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %b expected %b", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask : cyc
    task automatic wait_run;
        int i;
        for (i = 0; i < 200; i++) begin
            cyc(1);
            if (out_valid === 1'b1 && burst_en === 1'b1 && recal_busy === 1'b0) break;
        end
        chk(out_valid & burst_en & ~recal_busy, 1'b1);
    endtask : wait_run
    task automatic boot(input logic [3:0] c);
        @(posedge SYS_CLK);
        RST_N <= 1'b0;
        {mult, tsel, pol} <= c;
        repeat (20) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        wait_run;
    endtask : boot
    task automatic press;
        @(posedge SYS_CLK);
        touch <= 1'b1;
        @(posedge SYS_CLK);
        touch <= 1'b0;
        cyc(2);
    endtask : press
    task automatic pulse(input logic [7:0] n);
        @(posedge SYS_CLK);
        go <= 1'b1;
        len <= n;
        @(posedge SYS_CLK);
        go <= 1'b0;
    endtask : pulse
    // Whether the output is still on w cycles after a touch
    function automatic logic on_after(input logic [3:0] c, input int w);
        int mins;
        mins = (c[2:1] == 2'h2) ? 60 : ((c[2:1] == {1'b0, ~c[0]}) ? 15 : 0);
        return mins == 0 || w < mins * 10 * (c[3] ? 24 : 1);
    endfunction : on_after
    task automatic results;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results
    initial begin
        int n;
        void'($urandom(54));
        foreach (cfg[k]) begin
            boot(cfg[k]);
            press;
            cyc(135);
            chk(key_out, ~cfg[k][0]);
            cyc(60);
            chk(key_out, on_after(cfg[k], 200) ^ cfg[k][0]);
            $display("config %0d done", k);
        end
        boot(4'h2);
        n = $urandom_range(7, 2);
        repeat (n) press;
        chk(key_out, n[0]);
        if (n[0]) press;
        $display("toggle test done");
        press;
        cyc(100);
        pulse(8'($urandom_range(14, 6)));
        cyc(4);
        chk(burst_en, 1'b0);
        cyc(6);
        wait_run;
        cyc(100);
        chk(key_out, 1'b1);
        cyc(60);
        chk(key_out, 1'b0);
        $display("sustain test done");
        press;
        pulse(8'h28);
        cyc(26);
        chk(key_out, 1'b0);
        press;
        chk(key_out, 1'b0);
        cyc(14);
        wait_run;
        chk(key_out, 1'b0);
        $display("cancel test done");
        results;
    end
    initial begin
        #100000;
        n_fail++;
        results;
    end
endmodule : tb_auto_off_override_timer
